//--- design/fse_pkg.sv
// Package of constants and types for the field set evaluation block
package fse_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_CASEDEF  = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;
    // Control field positions
    localparam int CTRL_MULTI    = 0;
    localparam int CTRL_ONEHOT   = 1;
    localparam int CTRL_SLOWRESP = 2;
    localparam int CTRL_INTERIOR = 3;
    localparam int CTRL_SIMUL    = 4;
    // Reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] CASEDEF_RST = 32'h0000_000f;
    // Interrupt event bit positions
    localparam int EV_PROT  = 0;
    localparam int EV_WARN  = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_RESTART = 3;
    localparam int NUM_EV   = 4;
    // Case count and selection width
    localparam int NUM_CASES = 4;
    localparam int SEL_W     = 2;
    // Response times in ms and clock rate
    localparam int RESP_FAST_MS = 60;
    localparam int RESP_SLOW_MS = 120;
    localparam int CLK_KHZ      = 100000;
    localparam int RESP_FAST_CYC = RESP_FAST_MS * CLK_KHZ;
    localparam int RESP_SLOW_CYC = RESP_SLOW_MS * CLK_KHZ;
    localparam int CNT_W         = 24;
    // Evaluation states
    typedef enum logic [1:0] {
        FSE_RUN,
        FSE_TRIPPED,
        FSE_FAULT
    } fse_state_t;
endpackage

//--- design/fse_det_if.sv
// Interface carrying detection results between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface fse_det_if;
    logic [3:0] prot_hit;   // Protective field hit per case
    logic [3:0] warn_hit;   // Warning field hit per case
    logic [1:0] case_idx;   // Active case index
    logic       sel_fault;  // Selection coding fault
    modport src (output prot_hit, warn_hit, case_idx, sel_fault);
    modport dst (input prot_hit, warn_hit, case_idx, sel_fault);
endinterface
`default_nettype wire

//--- design/fse_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module fse_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;

    // Next value of the first stage
    always_comb begin
        meta_d = d_i;
    end

    // Register the two stages
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

//--- design/fse_case_sel.sv
// Case selection decoder and registering of the protective and warning detection inputs for all cases
`timescale 1ns/1ps
`default_nettype none
module fse_case_sel (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       multi_i,
    input  wire logic       onehot_i,
    input  wire logic [3:0] case_def_i,
    input  wire logic [3:0] sel_a_i,
    input  wire logic [3:0] prot_i,
    input  wire logic [3:0] warn_i,
    fse_det_if.src          det
);
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic       flt_q;
    logic       flt_d;
    logic [3:0] ph_q;
    logic [3:0] ph_d;
    logic [3:0] wh_q;
    logic [3:0] wh_d;

    // Decode the selection pins into a case and check coding
    always_comb begin
        idx_d = 2'h0;
        flt_d = 1'b0;
        if (multi_i) begin
            if (!onehot_i) begin
                // Complementary pairs: bits 0/1 and 2/3 must differ
                flt_d = (sel_a_i[0] == sel_a_i[1]) || (sel_a_i[2] == sel_a_i[3]); // RULE5 RULE11
                idx_d = {sel_a_i[2], sel_a_i[0]};
            end else begin
                // One-hot: exactly one of four active
                case (sel_a_i)
                    4'h1: idx_d = 2'h0;
                    4'h2: idx_d = 2'h1;
                    4'h4: idx_d = 2'h2;
                    4'h8: idx_d = 2'h3;
                    default: flt_d = 1'b1; // RULE5 RULE11
                endcase
            end
            if (!case_def_i[idx_d]) begin
                flt_d = 1'b1; // RULE11
            end
        end
        // Single-case variant never switches
        if (!multi_i) begin
            idx_d = 2'h0; // RULE9
        end
        ph_d = prot_i;
        wh_d = warn_i;
    end

    // Register the decode
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            idx_q <= 2'h0;
            flt_q <= 1'b1;
            ph_q  <= 4'h0;
            wh_q  <= 4'h0;
        end else begin
            idx_q <= idx_d; // RULE3
            flt_q <= flt_d;
            ph_q  <= ph_d;
            wh_q  <= wh_d;
        end
    end

    assign det.case_idx  = idx_q;
    assign det.sel_fault = flt_q;
    assign det.prot_hit  = ph_q;
    assign det.warn_hit  = wh_q;
endmodule
`default_nettype wire

//--- design/fse_top.sv
// Field set evaluation: output switching, diagnostics and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1 - Object in active protective field switches safety outputs off.
// RULE2 - Object in warning field raises warning, outputs stay on.
// RULE3 - Four cases, chosen at run time by static selection levels.
// RULE4 - Each case: selection condition, field pair, optional simultaneous pair without outputs.
// RULE5 - Two selection inputs, complementary or one-hot; single-case variant has none.
// RULE6 - One safety output pair shared by all cases.
// RULE7 - Three diagnostics: warning, restart button pressed, error or contamination.
// RULE8 - Interior use: restart only with protective field clear.
// RULE9 - Single-case variant: one field set, no switching; multi: up to four.
// RULE10 - Response time selectable: 60 ms or 120 ms.
// RULE11 - Undefined or badly coded selection is a fault; outputs off.
module fse_top #(
    parameter int RESP_FAST = fse_pkg::RESP_FAST_CYC,
    parameter int RESP_SLOW = fse_pkg::RESP_SLOW_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hwdata_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Pins
    input  wire logic [3:0]  case_sel_i,
    input  wire logic [3:0]  prot_det_i,
    input  wire logic [3:0]  warn_det_i,
    input  wire logic [3:0]  simul_det_i,
    input  wire logic        restart_btn_i,
    input  wire logic        contam_i,
    output logic       [1:0] safety_switch_output_o,
    output logic             diag_warn_o,
    output logic             diag_button_o,
    output logic             diag_error_o,
    output logic             irq_o
);
    logic [3:0] sel_s;
    logic [3:0] prot_s;
    logic [3:0] warn_s;
    logic [3:0] simul_s;
    logic       btn_s;
    logic       contam_s;

    fse_det_if det ();

    // Synchronise all pin inputs
    fse_sync #(.W(18)) u_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({case_sel_i, prot_det_i, warn_det_i, simul_det_i, restart_btn_i, contam_i}),
        .q_o     ({sel_s, prot_s, warn_s, simul_s, btn_s, contam_s})
    );

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [3:0]  casedef_q;
    logic [3:0]  casedef_d;

    fse_case_sel u_sel (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .multi_i    (ctrl_q[fse_pkg::CTRL_MULTI]),
        .onehot_i   (ctrl_q[fse_pkg::CTRL_ONEHOT]),
        .case_def_i (casedef_q),
        .sel_a_i    (sel_s),
        .prot_i     (prot_s),
        .warn_i     (warn_s),
        .det        (det.src)
    );

    // Evaluation of the active case
    logic prot_now;
    logic warn_now;
    logic simul_now;
    always_comb begin
        prot_now  = det.prot_hit[det.case_idx]; // RULE4
        warn_now  = det.warn_hit[det.case_idx]; // RULE4
        // Simultaneous pair only reported, never switches outputs
        simul_now = ctrl_q[fse_pkg::CTRL_SIMUL] && simul_s[det.case_idx]; // RULE4
    end

    // Response time counter and output state machine
    fse_pkg::fse_state_t st_q;
    fse_pkg::fse_state_t st_d;
    logic [31:0] rt_q;
    logic [31:0] rt_d;
    logic [1:0]  oss_q;
    logic [1:0]  oss_d;
    logic        restart_ev;
    logic [31:0] resp_lim;

    always_comb begin
        resp_lim = ctrl_q[fse_pkg::CTRL_SLOWRESP] ? 32'(RESP_SLOW) : 32'(RESP_FAST); // RULE10
        st_d       = st_q;
        rt_d       = rt_q;
        restart_ev = 1'b0;
        case (st_q)
            fse_pkg::FSE_RUN: begin
                if (det.sel_fault) begin
                    st_d = fse_pkg::FSE_FAULT; // RULE11
                end else if (prot_now) begin
                    // Confirm the intrusion over the response window
                    if (rt_q >= resp_lim - 32'h1) begin
                        st_d = fse_pkg::FSE_TRIPPED; // RULE1
                        rt_d = 32'h0;
                    end else begin
                        rt_d = rt_q + 32'h1; // RULE10
                    end
                end else begin
                    rt_d = 32'h0;
                end
            end
            fse_pkg::FSE_TRIPPED, fse_pkg::FSE_FAULT: begin
                rt_d = 32'h0;
                // Restart allowed only with clear field and good selection
                if (btn_s && !prot_now && !det.sel_fault) begin // RULE8
                    st_d       = fse_pkg::FSE_RUN;
                    restart_ev = 1'b1;
                end else if (!ctrl_q[fse_pkg::CTRL_INTERIOR] && !prot_now && !det.sel_fault
                             && st_q == fse_pkg::FSE_TRIPPED) begin
                    st_d       = fse_pkg::FSE_RUN;
                end
            end
            default: begin
                st_d = fse_pkg::FSE_FAULT;
            end
        endcase
        // One shared pair for every case
        oss_d = (st_d == fse_pkg::FSE_RUN) ? 2'h3 : 2'h0; // RULE6 RULE1
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_q  <= fse_pkg::FSE_FAULT;
            rt_q  <= 32'h0;
            oss_q <= 2'h0;
        end else begin
            st_q  <= st_d;
            rt_q  <= rt_d;
            oss_q <= oss_d;
        end
    end

    // Diagnostic outputs
    logic dw_q;
    logic dw_d;
    logic db_q;
    logic db_d;
    logic de_q;
    logic de_d;
    always_comb begin
        dw_d = warn_now || simul_now; // RULE2 RULE7
        db_d = btn_s; // RULE7
        de_d = det.sel_fault || contam_s; // RULE7
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dw_q <= 1'b0;
            db_q <= 1'b0;
            de_q <= 1'b1;
        end else begin
            dw_q <= dw_d;
            db_q <= db_d;
            de_q <= de_d;
        end
    end

    // AHB-Lite address phase capture
    logic       wr_pend_q;
    logic       wr_pend_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic       rd_pend_d;
    logic       take;
    always_comb begin
        take      = hsel_i && hready_i && htrans_i[1];
        wr_pend_d = take && hwrite_i;
        rd_pend_d = take && !hwrite_i;
        addr_d    = take ? haddr_i : addr_q;
    end

    // Register writes and sticky interrupt status
    logic [fse_pkg::NUM_EV-1:0] ist_q;
    logic [fse_pkg::NUM_EV-1:0] ist_d;
    logic [fse_pkg::NUM_EV-1:0] ien_q;
    logic [fse_pkg::NUM_EV-1:0] ien_d;
    logic [fse_pkg::NUM_EV-1:0] ev;
    logic                       irq_d;
    logic                       irq_q;
    always_comb begin
        ctrl_d    = ctrl_q;
        casedef_d = casedef_q;
        ien_d     = ien_q;
        ist_d     = ist_q;
        ev        = '0;
        ev[fse_pkg::EV_PROT]    = prot_now;
        ev[fse_pkg::EV_WARN]    = warn_now;
        ev[fse_pkg::EV_FAULT]   = det.sel_fault || contam_s;
        ev[fse_pkg::EV_RESTART] = restart_ev;
        if (wr_pend_q) begin
            case (addr_q)
                fse_pkg::OFF_CTRL:    ctrl_d    = hwdata_i;
                fse_pkg::OFF_CASEDEF: casedef_d = hwdata_i[3:0];
                fse_pkg::OFF_IRQ_EN:  ien_d     = hwdata_i[fse_pkg::NUM_EV-1:0];
                fse_pkg::OFF_IRQ_CLR: ist_d     = ist_q & ~hwdata_i[fse_pkg::NUM_EV-1:0];
                default: ;
            endcase
        end
        // Set wins over clear
        ist_d = ist_d | ev;
        irq_d = |(ist_d & ien_d);
    end

    // Read data mux
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    always_comb begin
        rdata_d = 32'h0;
        if (rd_pend_d) begin
            case (haddr_i)
                fse_pkg::OFF_CTRL:     rdata_d = ctrl_q;
                fse_pkg::OFF_CASEDEF:  rdata_d = {28'h0, casedef_q};
                fse_pkg::OFF_STATUS:   rdata_d = {22'h0, det.case_idx, st_q, oss_q, db_q, dw_q, de_q, prot_now};
                fse_pkg::OFF_IRQ_STAT: rdata_d = {28'h0, ist_q};
                fse_pkg::OFF_IRQ_EN:   rdata_d = {28'h0, ien_q};
                default:               rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q    <= fse_pkg::CTRL_RST;
            casedef_q <= fse_pkg::CASEDEF_RST[3:0];
            ien_q     <= '0;
            ist_q     <= '0;
            irq_q     <= 1'b0;
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h0;
            rdata_q   <= 32'h0;
        end else begin
            ctrl_q    <= ctrl_d;
            casedef_q <= casedef_d;
            ien_q     <= ien_d;
            ist_q     <= ist_d;
            irq_q     <= irq_d;
            wr_pend_q <= wr_pend_d;
            addr_q    <= addr_d;
            rdata_q   <= rdata_d;
        end
    end

    // Outputs straight from flip-flops, except hreadyout_o and hresp_o tied to constants
    assign hrdata_o               = rdata_q;
    assign hreadyout_o            = 1'b1;
    assign hresp_o                = 1'b0;
    assign safety_switch_output_o = oss_q;
    assign diag_warn_o            = dw_q;
    assign diag_button_o          = db_q;
    assign diag_error_o           = de_q;
    assign irq_o                  = irq_q;
endmodule
`default_nettype wire

//--- sim/fse_props.sv
// Checker for the field set evaluation top
`timescale 1ns/1ps
`default_nettype none
module fse_props #(
    parameter int RESP_FAST = 4,
    parameter int RESP_SLOW = 16
) (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic [3:0] case_sel_i,
    input wire logic [3:0] prot_det_i,
    input wire logic [3:0] warn_det_i,
    input wire logic       restart_btn_i,
    input wire logic       contam_i,
    input wire logic [1:0] safety_switch_output_o,
    input wire logic       diag_warn_o,
    input wire logic       diag_button_o,
    input wire logic       diag_error_o
);
    int hit_q;
    int hit_d;
    // Cycles with every protective field occupied, saturating
    always_comb begin
        hit_d = (prot_det_i == 4'hf) ? hit_q + 1 : 0;
        if (hit_d > RESP_SLOW + 16) hit_d = RESP_SLOW + 16;
    end
    // Counter register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) hit_q <= 0;
        else hit_q <= hit_d;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // Output pair: both bits equal, and behaviour against field occupancy
    chk_trip_held: assert property (hit_q >= RESP_SLOW + 8 |-> safety_switch_output_o == 2'b00)
        else $error("outputs on with field occupied");
    chk_pair_equal: assert property (safety_switch_output_o[0] == safety_switch_output_o[1])
        else $error("output pair split");
    chk_no_restart: assert property (hit_q >= 6 && safety_switch_output_o == 2'b00
        |=> !safety_switch_output_o[0]) else $error("restart with field occupied");
    chk_trip_delay: assert property (safety_switch_output_o == 2'b11 && prot_det_i == 4'hf &&
        $past(prot_det_i) == 4'h0 && $stable(case_sel_i) && !contam_i && !$past(contam_i)
        |=> safety_switch_output_o == 2'b11 [*3]) else $error("trip before response window");
    chk_quiet_on: assert property ((prot_det_i == 4'h0 && !contam_i && $stable(case_sel_i)) [*6]
        ##0 safety_switch_output_o == 2'b11 |=> safety_switch_output_o == 2'b11) else $error("trip without cause");
    // Diagnostic outputs
    chk_warn_diag: assert property (warn_det_i == 4'hf [*5] |-> diag_warn_o)
        else $error("warning not shown");
    chk_button_diag: assert property (restart_btn_i [*5] |-> diag_button_o)
        else $error("button not shown");
    chk_contam_err: assert property (contam_i [*5] |-> diag_error_o)
        else $error("contamination not shown");
    cover property ($fell(safety_switch_output_o[0]));
    cover property ($rose(safety_switch_output_o[0]));
    cover property ($rose(diag_warn_o));
endmodule
bind fse_top fse_props #(.RESP_FAST(RESP_FAST), .RESP_SLOW(RESP_SLOW)) u_props (
    .clk_i(clk_i), .reset_i(reset_i), .case_sel_i(case_sel_i), .prot_det_i(prot_det_i),
    .warn_det_i(warn_det_i), .restart_btn_i(restart_btn_i), .contam_i(contam_i),
    .safety_switch_output_o(safety_switch_output_o), .diag_warn_o(diag_warn_o),
    .diag_button_o(diag_button_o), .diag_error_o(diag_error_o));
`default_nettype wire

//--- sim/fse_ctrl_model.sv
// Behavioural machine controller: case selection and restart button
`timescale 1ns/1ps
`default_nettype none
module fse_ctrl_model (
    input  wire logic       clk_i,
    output logic      [3:0] case_sel_o,
    output logic            restart_btn_o
);
    initial begin
        case_sel_o = 4'h0;
        restart_btn_o = 1'b0;
    end
    // Static selection levels, held until the next call
    task automatic select(input logic [1:0] c, input logic onehot);
        @(posedge clk_i);
        if (onehot) case_sel_o <= 4'h1 << c;
        else case_sel_o <= {~c[1], c[1], ~c[0], c[0]};
    endtask
    // Raw code, used for badly coded selections
    task automatic raw(input logic [3:0] v);
        @(posedge clk_i);
        case_sel_o <= v;
    endtask
    // Button held long enough to pass the pin synchroniser
    task automatic press();
        @(posedge clk_i);
        restart_btn_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        restart_btn_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the field set evaluation top
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int FAST = 4;
    localparam int SLOW = 16;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic [3:0]  case_sel;
    logic [3:0]  prot = 4'h0;
    logic [3:0]  warn = 4'h0;
    logic [3:0]  simul = 4'h0;
    logic        btn;
    logic        contam = 1'b0;
    logic [1:0]  oss;
    logic        dwarn;
    logic        derr;
    logic        dbtn;
    logic        hresp;
    logic        irq;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    always #5 clk_i = ~clk_i;
    fse_ctrl_model ctrl (.clk_i(clk_i), .case_sel_o(case_sel), .restart_btn_o(btn));
    fse_top #(.RESP_FAST(FAST), .RESP_SLOW(SLOW)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'b010), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .case_sel_i(case_sel), .prot_det_i(prot), .warn_det_i(warn),
        .simul_det_i(simul), .restart_btn_i(btn), .contam_i(contam), .safety_switch_output_o(oss),
        .diag_warn_o(dwarn), .diag_button_o(dbtn), .diag_error_o(derr), .irq_o(irq));
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // One single word transfer, entered just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
        check(32'(hresp), 32'h0);
    endtask
    // Protective field hit then released
    task automatic trip(input int n);
        prot <= 4'hf;
        wt(n);
        check(32'(oss), 32'h0);
        prot <= 4'h0;
        wt(10);
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        wt(20);
        check(32'(derr), 32'h1);
        check(32'(oss), 32'h0);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rdc(fse_pkg::OFF_CTRL, fse_pkg::CTRL_RST);
        rdc(fse_pkg::OFF_CASEDEF, fse_pkg::CASEDEF_RST);
        rdc(8'h20, 32'h0);
        check(32'(derr), 32'h0);
        ctrl.select(2'd0, 1'b0);
        ctrl.press();
        check(32'(dbtn), 32'h1);
        wt(8);
        check(32'(dbtn), 32'h0);
        check(32'(oss), 32'h3);
        // Single-case variant ignores the selection pins
        ctrl.select(2'd1, 1'b0);
        prot <= 4'he;
        wt(FAST + 6);
        check(32'(oss), 32'h3);
        prot <= 4'h0;
        warn <= 4'hf;
        simul <= 4'hf;
        wt(8);
        check(32'(dwarn), 32'h1);
        check(32'(oss), 32'h3);
        warn <= 4'h0;
        wt(8);
        check(32'(dwarn), 32'h0);
        bus(fse_pkg::OFF_CTRL, 1'b1, 32'h10);
        wt(8);
        check(32'(dwarn), 32'h1);
        simul <= 4'h0;
        bus(fse_pkg::OFF_IRQ_CLR, 1'b1, 32'hf);
        bus(fse_pkg::OFF_IRQ_EN, 1'b1, 32'h1);
        wt(2);
        check(32'(irq), 32'h0);
        trip(FAST + 6);
        check(32'(irq), 32'h1);
        rdc(fse_pkg::OFF_IRQ_STAT, 32'h1 << fse_pkg::EV_PROT);
        check(32'(oss), 32'h3);
        bus(fse_pkg::OFF_IRQ_CLR, 1'b1, 32'hf);
        bus(fse_pkg::OFF_IRQ_EN, 1'b1, 32'h0);
        trip(FAST + 6);
        check(32'(irq), 32'h0);
        bus(fse_pkg::OFF_CTRL, 1'b1, 32'h8);
        prot <= 4'hf;
        wt(FAST + 6);
        ctrl.press();
        check(32'(oss), 32'h0);
        trip(2);
        check(32'(oss), 32'h0);
        ctrl.press();
        wt(8);
        check(32'(oss), 32'h3);
        bus(fse_pkg::OFF_CTRL, 1'b1, 32'h4);
        prot <= 4'hf;
        wt(FAST + 6);
        check(32'(oss), 32'h3);
        trip(SLOW);
        check(32'(oss), 32'h3);
        for (int m = 0; m < 2; m++) begin
            prot <= 4'hf;
            wt(FAST + 6);
            bus(fse_pkg::OFF_CTRL, 1'b1, {30'h0, m[0], 1'b1});
            for (int c = 0; c < 4; c++) begin
                ctrl.select(c[1:0], m[0]);
                prot <= ~(4'h1 << c);
                ctrl.press();
                wt(8);
                check(32'(oss), 32'h3);
                prot <= 4'h1 << c;
                wt(FAST + 6);
                check(32'(oss), 32'h0);
            end
        end
        ctrl.raw(4'h3);
        prot <= 4'h0;
        ctrl.press();
        wt(8);
        check(32'(oss), 32'h0);
        check(32'(derr), 32'h1);
        bus(fse_pkg::OFF_CTRL, 1'b1, 32'h1);
        bus(fse_pkg::OFF_CASEDEF, 1'b1, 32'h7);
        ctrl.select(2'd3, 1'b0);
        ctrl.press();
        wt(8);
        check(32'(oss), 32'h0);
        ctrl.select(2'd2, 1'b0);
        ctrl.press();
        wt(8);
        check(32'(oss), 32'h3);
        contam <= 1'b1;
        wt(8);
        check(32'(derr), 32'h1);
        rdc(fse_pkg::OFF_STATUS, 32'h232);
        end_of_test();
    end
endmodule
`default_nettype wire
